// >>> design/ocd_pkg.sv
// Purpose: Shared constants and types for the output clock sync and driver block.
// Assumes: Word-indexed registers; byte address is four times the index.
// Notes: Reset values match the power-up defaults of each register.
package ocd_pkg;
    localparam int ADDR_W = 16;
    localparam int IDX_W = 14;
    localparam logic [IDX_W-1:0] IDX_SYNC = 14'h0500;
    localparam logic [IDX_W-1:0] IDX_FOP = 14'h0501;
    localparam logic [IDX_W-1:0] IDX_OVR = 14'h0405;
    localparam logic [IDX_W-1:0] IDX_CTRL = 14'h0510;
    localparam logic [IDX_W-1:0] IDX_STAT = 14'h0511;
    localparam int SYNC_MASK0_BIT = 4;
    localparam int SYNC_MASK1_BIT = 5;
    localparam int SYNC_SRC_BIT = 2;
    localparam int SYNC_AUTO_LSB = 0;
    localparam int FOP_SEL33_BIT = 7;
    localparam int FOP_FMT_LSB = 4;
    localparam int FOP_POL_LSB = 2;
    localparam int FOP_STR_BIT = 1;
    localparam int FOP_EN_BIT = 0;
    localparam int OVR_BIT = 3;
    localparam int CTRL_XFER_BIT = 0;
    localparam int CTRL_MSYNC_BIT = 1;
    localparam int STAT_FREQ_BIT = 0;
    localparam int STAT_PHASE_BIT = 1;
    localparam int STAT_CAL_BIT = 2;
    localparam int STAT_LOCK_BIT = 3;
    localparam int STAT_RUN_LSB = 4;
    localparam int STAT_ARMED_BIT = 6;
    localparam logic [7:0] SYNC_RST = 8'h02;
    localparam logic [7:0] FOP_RST = 8'h10;
    localparam logic [7:0] OVR_RST = 8'h00;
    localparam logic [7:0] SYNC_WMASK = 8'h37;
    localparam int NUM_IN = 5;
    typedef enum logic [1:0] {
        OCD_AUTO_OFF = 2'b00,
        OCD_AUTO_FREQ = 2'b01,
        OCD_AUTO_PHASE = 2'b10,
        OCD_AUTO_RSVD = 2'b11
    } ocd_auto_t;
    typedef enum logic [2:0] {
        OCD_FMT_OFF = 3'b000,
        OCD_FMT_HSTL = 3'b001,
        OCD_FMT_LVDS = 3'b010,
        OCD_FMT_RSV3 = 3'b011,
        OCD_FMT_CMOS_PN = 3'b100,
        OCD_FMT_CMOS_P = 3'b101,
        OCD_FMT_CMOS_N = 3'b110,
        OCD_FMT_RSV7 = 3'b111
    } ocd_fmt_t;
    typedef enum logic {
        OCD_CH_HELD = 1'b0,
        OCD_CH_RUN = 1'b1
    } ocd_ch_t;
endpackage : ocd_pkg

// >>> design/ocd_sync3.sv
// Purpose: Three-stage synchroniser with agreement filter for pin levels.
// Assumes: Inputs are asynchronous to i_clock.
// Notes: A change is accepted once the second and third stages agree.
`timescale 1ns/1ps
module ocd_sync3 #(
    parameter int WIDTH = 1
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_level_q
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] agree;

    assign agree = ~(s2_q ^ s3_q);

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            o_level_q <= '0;
        end
        else
        begin
            s1_q <= i_async;
            s2_q <= s1_q;
            s3_q <= s2_q;
            o_level_q <= (agree & s3_q) | (~agree & o_level_q);
        end
    end
endmodule : ocd_sync3

// >>> design/ocd_drv.sv
// Purpose: Decodes the first output pair driver settings into driver controls.
// Assumes: Channel run state comes from the channel 0 sync logic.
// Notes: All outputs are registered.
`timescale 1ns/1ps
module ocd_drv (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic [7:0] i_cfg,
    input wire logic i_ch_run,
    output logic o_drv18_en_q,
    output logic o_drv33_en_q,
    output logic o_p_leg_q,
    output logic o_n_leg_q,
    output logic o_p_inv_q,
    output logic o_n_inv_q,
    output logic o_cmos_strong_q,
    output logic o_lvds_boost_q,
    output logic [2:0] o_fmt_q,
    output logic o_clk_gate_q
);
    ocd_pkg::ocd_fmt_t fmt;
    logic [1:0] pol;
    logic sel33;
    logic drv_on;
    logic p_leg;
    logic n_leg;
    logic fmt_ok;
    logic is_cmos;

    assign fmt = ocd_pkg::ocd_fmt_t'(i_cfg[ocd_pkg::FOP_FMT_LSB +: 3]);
    assign pol = i_cfg[ocd_pkg::FOP_POL_LSB +: 2];
    assign sel33 = i_cfg[ocd_pkg::FOP_SEL33_BIT];
    assign drv_on = sel33 | i_cfg[ocd_pkg::FOP_EN_BIT];
    assign fmt_ok = (fmt != ocd_pkg::OCD_FMT_RSV3) && (fmt != ocd_pkg::OCD_FMT_RSV7);
    assign is_cmos = fmt[2] && fmt_ok;
    assign p_leg = fmt_ok && (fmt != ocd_pkg::OCD_FMT_OFF) && (fmt != ocd_pkg::OCD_FMT_CMOS_N);
    assign n_leg = fmt_ok && (fmt != ocd_pkg::OCD_FMT_OFF) && (fmt != ocd_pkg::OCD_FMT_CMOS_P);

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_drv18_en_q <= 1'b0;
            o_drv33_en_q <= 1'b0;
            o_p_leg_q <= 1'b0;
            o_n_leg_q <= 1'b0;
            o_p_inv_q <= 1'b0;
            o_n_inv_q <= 1'b1;
            o_cmos_strong_q <= 1'b0;
            o_lvds_boost_q <= 1'b0;
            o_fmt_q <= ocd_pkg::OCD_FMT_HSTL;
            o_clk_gate_q <= 1'b0;
        end
        else
        begin
            o_drv18_en_q <= i_cfg[ocd_pkg::FOP_EN_BIT] & ~sel33;
            o_drv33_en_q <= sel33;
            o_p_leg_q <= p_leg & drv_on;
            o_n_leg_q <= n_leg & drv_on;
            o_p_inv_q <= pol[1];
            o_n_inv_q <= ~(pol[1] ^ pol[0]);
            o_cmos_strong_q <= sel33 & is_cmos & i_cfg[ocd_pkg::FOP_STR_BIT];
            o_lvds_boost_q <= (fmt == ocd_pkg::OCD_FMT_LVDS) & i_cfg[ocd_pkg::FOP_STR_BIT];
            o_fmt_q <= fmt_ok ? fmt : ocd_pkg::OCD_FMT_OFF;
            o_clk_gate_q <= i_ch_run & drv_on & (p_leg | n_leg);
        end
    end
endmodule : ocd_drv

// >>> design/ocd_top.sv
// Purpose: Output clock distribution sync control and first output driver settings.
// Assumes: APB slave, no wait states; lock inputs arrive from other domains.
// Notes: Channel run outputs gate the channel dividers; sync pulses reset them.
//
// Overview of operation
// - Channel 1 mask set releases its hold at once and ignores all sync events.
// - Channel 0 mask set releases its hold at once and ignores all sync events.
// - Unmasked channel stays held, outputs still, until a sync pulse arrives.
// - A mask bit never turns on an output driver by itself.
// - Sync source 0 syncs on next transfer strobe; 1 uses active reference.
// - No sync until output loop is calibrated and locked, unless overridden.
// - Auto sync: 00 off, 01 frequency lock, 10 phase lock, 11 reserved.
// - Format selects off, HSTL, LVDS or CMOS leg combinations; others reserved.
// - Polarity field sets leg polarities: PN, PP, NP, NN.
// - 3.3 V select makes the 3.3 V CMOS driver the first output mode.
// - Enable bit switches the 1.8 V driver; ignored while 3.3 V is selected.
// - Strength bit picks CMOS strength in 3.3 V mode and LVDS boost current.
// - Override set ignores output loop lock; sync settings govern regardless.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
module ocd_top #(
    parameter int ADDR_W = ocd_pkg::ADDR_W,
    parameter int NUM_CH = 2
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_digital_loop_freq_lock,
    input wire logic i_digital_loop_phase_lock,
    input wire logic i_output_analog_loop_cal_done,
    input wire logic i_output_analog_loop_locked,
    input wire logic i_ref_sync,
    output logic [NUM_CH-1:0] o_ch_run,
    output logic [NUM_CH-1:0] o_ch_sync,
    output logic o_first_output_pair_drv18_en,
    output logic o_first_output_pair_drv33_en,
    output logic o_first_output_pair_p_leg,
    output logic o_first_output_pair_n_leg,
    output logic o_first_output_pair_p_inv,
    output logic o_first_output_pair_n_inv,
    output logic o_first_output_pair_cmos_strong,
    output logic o_first_output_pair_lvds_boost,
    output logic [2:0] o_first_output_pair_fmt,
    output logic o_first_output_pair_clk_gate
);
    generate
        if (ADDR_W < ocd_pkg::IDX_W + 2 || NUM_CH != 2)
        begin : g_bad_param
            $error("ocd_top needs ADDR_W of at least 16 and exactly two channels.");
        end
    endgenerate

    logic [7:0] sync_reg_q;
    logic [7:0] fop_reg_q;
    logic ovr_q;
    logic xfer_q;
    logic msync_q;
    logic [ocd_pkg::NUM_IN-1:0] pins_async;
    logic [ocd_pkg::NUM_IN-1:0] pins_lvl;
    logic [ocd_pkg::NUM_IN-1:0] pins_prev_q;
    logic [ocd_pkg::NUM_IN-1:0] pins_rise;
    logic freq_lock;
    logic phase_lock;
    logic cal_done;
    logic aloop_lock;
    logic armed;
    logic src_event;
    logic auto_event;
    logic sync_fire;
    ocd_pkg::ocd_auto_t auto_mode;
    logic [NUM_CH-1:0] mask;
    logic [NUM_CH-1:0] run_q;
    logic [NUM_CH-1:0] syncp_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic setup;
    logic wr_en;
    logic [ocd_pkg::IDX_W-1:0] idx;
    logic hi_zero;
    logic hit_sync;
    logic hit_fop;
    logic hit_ovr;
    logic hit_ctrl;
    logic hit_stat;
    logic mapped;
    logic [7:0] stat_val;
    logic [7:0] rd_byte;

    // Lock and reference inputs come from other clock domains.
    assign pins_async = {i_ref_sync, i_output_analog_loop_locked,
        i_output_analog_loop_cal_done, i_digital_loop_phase_lock,
        i_digital_loop_freq_lock};

    ocd_sync3 #(
        .WIDTH(ocd_pkg::NUM_IN)
    ) u_sync3 (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_async(pins_async),
        .o_level_q(pins_lvl)
    );

    assign freq_lock = pins_lvl[0];
    assign phase_lock = pins_lvl[1];
    assign cal_done = pins_lvl[2];
    assign aloop_lock = pins_lvl[3];
    assign pins_rise = pins_lvl & ~pins_prev_q;

    // Register bus decode.
    assign idx = i_paddr[2 +: ocd_pkg::IDX_W];
    assign hi_zero = (i_paddr[1:0] == 2'b00) &&
        ((i_paddr >> (ocd_pkg::IDX_W + 2)) == '0);
    assign hit_sync = hi_zero && (idx == ocd_pkg::IDX_SYNC);
    assign hit_fop = hi_zero && (idx == ocd_pkg::IDX_FOP);
    assign hit_ovr = hi_zero && (idx == ocd_pkg::IDX_OVR);
    assign hit_ctrl = hi_zero && (idx == ocd_pkg::IDX_CTRL);
    assign hit_stat = hi_zero && (idx == ocd_pkg::IDX_STAT);
    assign mapped = hit_sync | hit_fop | hit_ovr | hit_ctrl | hit_stat;
    assign setup = i_psel && !i_penable;
    assign wr_en = i_psel && i_penable && pready_q && i_pwrite && !pslverr_q;

    assign stat_val = {1'b0, armed, run_q, aloop_lock, cal_done, phase_lock, freq_lock};
    assign rd_byte = hit_sync ? sync_reg_q :
        hit_fop ? fop_reg_q :
        hit_ovr ? (8'h01 << ocd_pkg::OVR_BIT) & {8{ovr_q}} :
        hit_stat ? stat_val : 8'h00;

    // Sync trigger selection.
    assign auto_mode = ocd_pkg::ocd_auto_t'(sync_reg_q[ocd_pkg::SYNC_AUTO_LSB +: 2]);
    assign mask = {sync_reg_q[ocd_pkg::SYNC_MASK1_BIT], sync_reg_q[ocd_pkg::SYNC_MASK0_BIT]};
    assign armed = ovr_q | (cal_done & aloop_lock);
    assign src_event = sync_reg_q[ocd_pkg::SYNC_SRC_BIT] ? pins_rise[4] : xfer_q;
    assign sync_fire = armed & (src_event | auto_event | msync_q);

    always_comb
    begin
        case (auto_mode)
            ocd_pkg::OCD_AUTO_OFF: auto_event = 1'b0;
            ocd_pkg::OCD_AUTO_FREQ: auto_event = pins_rise[0];
            ocd_pkg::OCD_AUTO_PHASE: auto_event = pins_rise[1];
            ocd_pkg::OCD_AUTO_RSVD: auto_event = 1'b0;
            default: auto_event = 1'b0;
        endcase
    end

    // Per-channel hold state; a set mask releases and shields the channel.
    generate
        for (genvar ch = 0; ch < NUM_CH; ch++)
        begin : g_ch
            ocd_pkg::ocd_ch_t st_q;
            ocd_pkg::ocd_ch_t st_d;
            logic sp_d;
            logic mask_prev_q;

            always_comb
            begin
                st_d = st_q;
                sp_d = 1'b0;
                case (st_q)
                    ocd_pkg::OCD_CH_HELD:
                    begin
                        if (mask[ch])
                        begin
                            st_d = ocd_pkg::OCD_CH_RUN;
                        end
                        else if (sync_fire)
                        begin
                            st_d = ocd_pkg::OCD_CH_RUN;
                            sp_d = 1'b1;
                        end
                    end
                    ocd_pkg::OCD_CH_RUN:
                    begin
                        if (!mask[ch] && sync_fire)
                        begin
                            sp_d = 1'b1;
                        end
                        else if (!mask[ch] && mask_prev_q)
                        begin
                            st_d = ocd_pkg::OCD_CH_HELD;
                        end
                    end
                    default:
                    begin
                        st_d = ocd_pkg::OCD_CH_HELD;
                    end
                endcase
            end

            always_ff @(posedge i_clock or negedge i_rst_n)
            begin
                if (!i_rst_n)
                begin
                    st_q <= ocd_pkg::OCD_CH_HELD;
                end
                else
                begin
                    st_q <= st_d;
                end
            end

            always_ff @(posedge i_clock or negedge i_rst_n)
            begin
                if (!i_rst_n)
                begin
                    syncp_q[ch] <= 1'b0;
                    mask_prev_q <= 1'b0;
                end
                else
                begin
                    syncp_q[ch] <= sp_d;
                    mask_prev_q <= mask[ch];
                end
            end

            assign run_q[ch] = (st_q == ocd_pkg::OCD_CH_RUN);
        end
    endgenerate

    // Configuration registers.
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sync_reg_q <= ocd_pkg::SYNC_RST;
            fop_reg_q <= ocd_pkg::FOP_RST;
            ovr_q <= ocd_pkg::OVR_RST[ocd_pkg::OVR_BIT];
        end
        else if (wr_en)
        begin
            if (hit_sync)
            begin
                sync_reg_q <= i_pwdata[7:0] & ocd_pkg::SYNC_WMASK;
            end
            if (hit_fop)
            begin
                fop_reg_q <= i_pwdata[7:0];
            end
            if (hit_ovr)
            begin
                ovr_q <= i_pwdata[ocd_pkg::OVR_BIT];
            end
        end
    end

    // Command strobes: one-cycle pulses from a write of one.
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            xfer_q <= 1'b0;
            msync_q <= 1'b0;
            pins_prev_q <= '0;
        end
        else
        begin
            xfer_q <= wr_en & hit_ctrl & i_pwdata[ocd_pkg::CTRL_XFER_BIT];
            msync_q <= wr_en & hit_ctrl & i_pwdata[ocd_pkg::CTRL_MSYNC_BIT];
            pins_prev_q <= pins_lvl;
        end
    end

    // Bus answer: ready one cycle after the setup phase.
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end
        else
        begin
            pready_q <= setup;
            pslverr_q <= setup & ~mapped;
            prdata_q <= (setup && !i_pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    ocd_drv u_drv (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_cfg(fop_reg_q),
        .i_ch_run(run_q[0]),
        .o_drv18_en_q(o_first_output_pair_drv18_en),
        .o_drv33_en_q(o_first_output_pair_drv33_en),
        .o_p_leg_q(o_first_output_pair_p_leg),
        .o_n_leg_q(o_first_output_pair_n_leg),
        .o_p_inv_q(o_first_output_pair_p_inv),
        .o_n_inv_q(o_first_output_pair_n_inv),
        .o_cmos_strong_q(o_first_output_pair_cmos_strong),
        .o_lvds_boost_q(o_first_output_pair_lvds_boost),
        .o_fmt_q(o_first_output_pair_fmt),
        .o_clk_gate_q(o_first_output_pair_clk_gate)
    );

    assign o_prdata = prdata_q;
    assign o_pready = pready_q;
    assign o_pslverr = pslverr_q;
    assign o_ch_run = run_q;
    assign o_ch_sync = syncp_q;
endmodule : ocd_top

// >>> dv/ocd_monitor.sv
// Purpose: Concurrent checks on the ports of the output clock sync and driver block.
// Assumes: One clock domain; byte address is four times the register index.
// Notes: Shadow copies of the mask bits and the driver settings follow APB writes.
`timescale 1ns/1ps
module ocd_monitor #(
    parameter int ADDR_W = 16,
    parameter int NUM_CH = 2
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic [NUM_CH-1:0] o_ch_run,
    input wire logic [NUM_CH-1:0] o_ch_sync,
    input wire logic o_first_output_pair_drv18_en,
    input wire logic o_first_output_pair_drv33_en,
    input wire logic o_first_output_pair_p_inv,
    input wire logic o_first_output_pair_n_inv,
    input wire logic o_first_output_pair_lvds_boost,
    input wire logic [2:0] o_first_output_pair_fmt
);
    logic [7:0] cfg_q;
    logic [1:0] mask_q;
    wire logic wr_ok;
    wire logic hit_sync;
    wire logic hit_fop;
    assign wr_ok = i_psel & i_penable & o_pready & i_pwrite & ~o_pslverr;
    assign hit_sync = (i_paddr == {ocd_pkg::IDX_SYNC, 2'b00});
    assign hit_fop = (i_paddr == {ocd_pkg::IDX_FOP, 2'b00});
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cfg_q <= ocd_pkg::FOP_RST;
            mask_q <= 2'b00;
        end
        else
        begin
            if (wr_ok && hit_fop)
            begin
                cfg_q <= i_pwdata[7:0];
            end
            if (wr_ok && hit_sync)
            begin
                mask_q <= i_pwdata[5:4];
            end
        end
    end
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);
    property p_pready_once;
        i_psel && !i_penable |=> o_pready ##1 !o_pready;
    endproperty
    a_pready_once: assert property (p_pready_once)
        else $error("pready not a single cycle after setup");
    property p_mask0_release;
        wr_ok && hit_sync && i_pwdata[4] |=> ##1 o_ch_run[0];
    endproperty
    a_mask0_release: assert property (p_mask0_release)
        else $error("channel 0 not released by its mask");
    property p_mask1_release;
        wr_ok && hit_sync && i_pwdata[5] |=> ##1 o_ch_run[1];
    endproperty
    a_mask1_release: assert property (p_mask1_release)
        else $error("channel 1 not released by its mask");
    property p_masked_quiet;
        (o_ch_sync[1:0] & $past(mask_q)) == 2'b00;
    endproperty
    a_masked_quiet: assert property (p_masked_quiet)
        else $error("sync pulse on a masked channel");
    property p_held_until_sync;
        $rose(o_ch_run[0]) |-> o_ch_sync[0] || mask_q[0];
    endproperty
    a_held_until_sync: assert property (p_held_until_sync)
        else $error("channel 0 released without sync or mask");
    property p_drv18;
        o_first_output_pair_drv18_en == ($past(cfg_q[0]) && !$past(cfg_q[7]));
    endproperty
    a_drv18: assert property (p_drv18)
        else $error("low voltage driver enable wrong");
    property p_drv33;
        o_first_output_pair_drv33_en == $past(cfg_q[7]);
    endproperty
    a_drv33: assert property (p_drv33)
        else $error("high voltage driver select wrong");
    property p_fmt;
        o_first_output_pair_fmt == (($past(cfg_q[5:4]) == 2'b11) ? 3'h0 : $past(cfg_q[6:4]));
    endproperty
    a_fmt: assert property (p_fmt)
        else $error("format output wrong");
    property p_polarity;
        o_first_output_pair_p_inv == $past(cfg_q[3])
            && o_first_output_pair_n_inv == ($past(cfg_q[3]) == $past(cfg_q[2]));
    endproperty
    a_polarity: assert property (p_polarity)
        else $error("polarity outputs wrong");
    property p_boost;
        o_first_output_pair_lvds_boost == ($past(cfg_q[6:4]) == 3'h2 && $past(cfg_q[1]));
    endproperty
    a_boost: assert property (p_boost)
        else $error("lvds boost wrong");
endmodule : ocd_monitor

bind ocd_top ocd_monitor #(.ADDR_W(ADDR_W), .NUM_CH(NUM_CH)) i_mon (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .o_ch_run(o_ch_run), .o_ch_sync(o_ch_sync),
    .o_first_output_pair_drv18_en(o_first_output_pair_drv18_en),
    .o_first_output_pair_drv33_en(o_first_output_pair_drv33_en),
    .o_first_output_pair_p_inv(o_first_output_pair_p_inv),
    .o_first_output_pair_n_inv(o_first_output_pair_n_inv),
    .o_first_output_pair_lvds_boost(o_first_output_pair_lvds_boost),
    .o_first_output_pair_fmt(o_first_output_pair_fmt));

// >>> dv/test_output_clock_sync_and_driver_config.sv
// Purpose: Self-checking bench for the output clock sync and driver block.
// Assumes: APB master in the bench; lock and reference pins driven directly.
// Notes: Expected values come from a small behavioural model of the settings.
`timescale 1ns/1ps
module test_output_clock_sync_and_driver_config;
    localparam logic [15:0] A_SYNC = {ocd_pkg::IDX_SYNC, 2'b00};
    localparam logic [15:0] A_FOP = {ocd_pkg::IDX_FOP, 2'b00};
    localparam logic [15:0] A_STAT = {ocd_pkg::IDX_STAT, 2'b00};
    localparam logic [15:0] A_OVR = {ocd_pkg::IDX_OVR, 2'b00};
    localparam logic [15:0] A_CTRL = {ocd_pkg::IDX_CTRL, 2'b00};
    localparam logic [15:0] TBL [14] = '{16'h0000, 16'h0043, 16'h0083, 16'h0480, 16'h0493,
        16'h019B, 16'h01A0, 16'h02A3, 16'h0298, 16'h0098, 16'h03A0, 16'h008B, 16'h1082,
        16'h2081};
    logic i_clock = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_psel = 1'b0;
    logic i_penable = 1'b0;
    logic i_pwrite = 1'b0;
    logic [15:0] i_paddr = 16'h0000;
    logic [31:0] i_pwdata = 32'h0000_0000;
    logic i_freq = 1'b0;
    logic i_phase = 1'b0;
    logic i_cal = 1'b0;
    logic i_lock = 1'b0;
    logic i_ref_sync = 1'b0;
    logic [31:0] o_prdata;
    logic o_pready;
    logic o_pslverr;
    logic [1:0] o_ch_run;
    logic [1:0] o_ch_sync;
    logic [11:0] drv;
    logic [31:0] rdata;
    logic [31:0] rnd;
    logic [7:0] cfg;
    logic [15:0] e;
    logic rerr;
    int bad_count = 0;
    int compares = 0;
    int n0;
    int n1;
    integer seed = 71335;
    always #10 i_clock = ~i_clock;
    ocd_top i_dut (
        .i_clock(i_clock), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr), .i_digital_loop_freq_lock(i_freq),
        .i_digital_loop_phase_lock(i_phase), .i_output_analog_loop_cal_done(i_cal),
        .i_output_analog_loop_locked(i_lock), .i_ref_sync(i_ref_sync),
        .o_ch_run(o_ch_run), .o_ch_sync(o_ch_sync),
        .o_first_output_pair_drv18_en(drv[11]), .o_first_output_pair_drv33_en(drv[10]),
        .o_first_output_pair_p_leg(drv[9]), .o_first_output_pair_n_leg(drv[8]),
        .o_first_output_pair_p_inv(drv[7]), .o_first_output_pair_n_inv(drv[6]),
        .o_first_output_pair_cmos_strong(drv[5]), .o_first_output_pair_lvds_boost(drv[4]),
        .o_first_output_pair_fmt(drv[3:1]), .o_first_output_pair_clk_gate(drv[0]));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [15:0] addr, input logic [31:0] data);
        int n;
        @(posedge i_clock);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= wr;
        i_paddr <= addr;
        i_pwdata <= data;
        @(posedge i_clock);
        i_penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge i_clock);
            n++;
        end
        while (o_pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            bad_count++;
        end
        rdata = o_prdata;
        rerr = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask : apb
    task automatic do_reset();
        i_rst_n <= 1'b0;
        repeat (10) @(posedge i_clock);
        i_rst_n <= 1'b1;
    endtask : do_reset
    task automatic watch();
        n0 = 0;
        n1 = 0;
        repeat (12)
        begin
            @(posedge i_clock);
            #1;
            n0 += (o_ch_sync[0] === 1'b1) ? 1 : 0;
            n1 += (o_ch_sync[1] === 1'b1) ? 1 : 0;
        end
    endtask : watch
    function automatic logic [11:0] drv_model(input logic [7:0] c, input logic run0);
        logic [2:0] f;
        logic on;
        logic bp;
        logic bn;
        f = (c[5:4] == 2'b11) ? 3'h0 : c[6:4];
        on = c[0] | c[7];
        bp = (f == 3'h1) || (f == 3'h2) || (f == 3'h4) || (f == 3'h5);
        bn = (f == 3'h1) || (f == 3'h2) || (f == 3'h4) || (f == 3'h6);
        return {c[0] & ~c[7], c[7], bp & on, bn & on, c[3], ~(c[3] ^ c[2]),
            c[7] & f[2] & c[1], (f == 3'h2) & c[1], f, run0 & on & (bp | bn)};
    endfunction : drv_model
    task automatic conclude();
        if (bad_count == 0 && compares > 0)
        begin
            $display("bench passed");
        end
        else
        begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude
    initial
    begin
        #200_000;
        bad_count++;
        conclude();
    end
    initial
    begin
        do_reset();
        apb(1'b0, A_SYNC, 32'h0000_0000);
        check(rdata, 32'h0000_0002);
        apb(1'b0, A_FOP, 32'h0000_0000);
        check(rdata, 32'h0000_0010);
        apb(1'b0, 16'h0008, 32'h0000_0000);
        check({rdata[30:0], rerr}, 32'h0000_0001);
        apb(1'b1, A_SYNC, 32'hFFFF_FFFF);
        apb(1'b0, A_SYNC, 32'h0000_0000);
        check(rdata, 32'h0000_0037);
        for (int f = 0; f < 8; f++)
        begin
            for (int k = 0; k < 3; k++)
            begin
                rnd = $random(seed);
                cfg = {rnd[7] & (f >= 4 && f <= 6), f[2:0], rnd[3:0]};
                apb(1'b1, A_FOP, {rnd[31:8], cfg});
                apb(1'b0, A_FOP, 32'h0000_0000);
                check(rdata, {24'h00_0000, cfg});
                check({20'h0_0000, drv}, {20'h0_0000, drv_model(cfg, 1'b1)});
            end
        end
        for (int t = 0; t < 14; t++)
        begin
            e = TBL[t];
            apb(1'b1, A_SYNC, {24'h00_0000, e[15:8]});
            apb(1'b1, A_OVR, {28'h000_0000, e[7], 3'h0});
            i_cal <= e[6];
            i_lock <= e[6];
            repeat (8) @(posedge i_clock);
            case (e[5:3])
                3'h0: apb(1'b1, A_CTRL, 32'h0000_0001);
                3'h1: apb(1'b1, A_CTRL, 32'h0000_0002);
                3'h2: i_ref_sync <= 1'b1;
                3'h3: i_freq <= 1'b1;
                default: i_phase <= 1'b1;
            endcase
            watch();
            check(32'(n0), {31'h0, e[0]});
            check(32'(n1), {31'h0, e[1]});
            i_ref_sync <= 1'b0;
            i_freq <= 1'b0;
            i_phase <= 1'b0;
            repeat (8) @(posedge i_clock);
        end
        do_reset();
        check(32'(o_ch_run), 32'h0000_0000);
        apb(1'b1, A_SYNC, 32'h0000_0010);
        repeat (2) @(posedge i_clock);
        check(32'({o_ch_run, drv[11:10]}), 32'h0000_0004);
        apb(1'b1, A_FOP, 32'h0000_0011);
        repeat (3) @(posedge i_clock);
        check({20'h0_0000, drv}, {20'h0_0000, drv_model(8'h11, 1'b1)});
        apb(1'b1, A_SYNC, 32'h0000_0030);
        repeat (2) @(posedge i_clock);
        check(32'(o_ch_run), 32'h0000_0003);
        apb(1'b1, A_SYNC, 32'h0000_0000);
        repeat (2) @(posedge i_clock);
        check(32'(o_ch_run), 32'h0000_0000);
        apb(1'b1, A_OVR, 32'h0000_0008);
        apb(1'b0, A_OVR, 32'h0000_0000);
        check(rdata, 32'h0000_0008);
        apb(1'b0, A_STAT, 32'h0000_0000);
        check(rdata, 32'h0000_0040);
        conclude();
    end
endmodule : test_output_clock_sync_and_driver_config
